// file: verilog/rtcw_pkg.sv
package rtcw_pkg;
   // Register byte offsets
   localparam logic [7:0] A_DT_CNT = 8'h00;
   localparam logic [7:0] A_DT_ALM = 8'h04;
   localparam logic [7:0] A_DT_LD = 8'h08;
   localparam logic [7:0] A_YR_CNT = 8'h0C;
   localparam logic [7:0] A_YR_ALM = 8'h10;
   localparam logic [7:0] A_YR_LD = 8'h14;
   localparam logic [7:0] A_TRIM = 8'h18;
   localparam logic [7:0] A_MASK = 8'h1C;
   localparam logic [7:0] A_RAW = 8'h20;
   localparam logic [7:0] A_MST = 8'h24;
   localparam logic [7:0] A_CLR = 8'h28;
   localparam logic [7:0] A_TCNT = 8'h2C;
   localparam logic [7:0] A_TCTL = 8'h30;
   localparam logic [7:0] A_TLD1 = 8'h34;
   localparam logic [7:0] A_TLD2 = 8'h38;
   localparam logic [7:0] A_PAT0 = 8'h3C;
   localparam logic [7:0] A_TIN = 8'h4C;
   localparam int PAT_WORDS = 4;
   // Date/time field positions
   localparam int SEC_L = 0;
   localparam int MIN_L = 6;
   localparam int HOUR_L = 12;
   localparam int WDAY_L = 17;
   localparam int MDAY_L = 20;
   localparam int MON_L = 25;
   localparam int MON_H = 28;
   // Interrupt bits
   localparam int IRQ_ALM = 0;
   localparam int IRQ_TMR = 1;
   // Timer control bits
   localparam int TC_EN = 0;
   localparam int TC_OS = 1;
   localparam int TC_SELF = 2;
   localparam int TC_PL_L = 4;
   localparam int TC_PL_H = 10;
   // Reset values
   localparam logic [5:0] RST_SEC = 6'h00;
   localparam logic [5:0] RST_MIN = 6'h00;
   localparam logic [4:0] RST_HOUR = 5'h00;
   localparam logic [2:0] RST_WDAY = 3'h1;
   localparam logic [4:0] RST_MDAY = 5'h01;
   localparam logic [3:0] RST_MON = 4'h1;
   localparam logic [15:0] RST_YEAR = 16'h2000;
   localparam logic [15:0] RST_YALM = 16'h2000;
   localparam logic [14:0] RST_TRIM = 15'h7FFF;
   localparam logic [31:0] RST_TCNT = 32'h0FFFFFFF;
   // Counter limits
   localparam logic [5:0] SEC_MAX = 6'h3B;
   localparam logic [5:0] MIN_MAX = 6'h3B;
   localparam logic [4:0] HOUR_MAX = 5'h17;
   localparam logic [2:0] WDAY_MAX = 3'h7;
   localparam logic [3:0] MON_MAX = 4'hC;
   localparam logic [15:0] YEAR_MAX = 16'h1000;
   localparam logic [3:0] M_FEB = 4'h2;
   localparam logic [3:0] M_APR = 4'h4;
   localparam logic [3:0] M_JUN = 4'h6;
   localparam logic [3:0] M_SEP = 4'h9;
   localparam logic [3:0] M_NOV = 4'hB;
   localparam logic [4:0] D_31 = 5'h1F;
   localparam logic [4:0] D_30 = 5'h1E;
   localparam logic [4:0] D_29 = 5'h1D;
   localparam logic [4:0] D_28 = 5'h1C;
   typedef enum logic {T_STOP = 1'b0, T_RUN = 1'b1} rtcw_tstate_t;
endpackage

// file: verilog/rtcw_top.sv
// Summary of operation
// - 32-bit down-counter steps on each rising 32 kHz edge, interrupting on the tick after it reaches zero.
// - Oneshot select 0 runs periodically, reloading each time zero passes.
// - Periodic reload takes first load on pattern bit 0, second on 1.
// - Oneshot select 1 interrupts once, halts; enable write, or a load write in self-start mode, restarts.
// - Pattern index advances per interrupt over control bits [10:4] bits.
// - Load register writes while running are ignored.
// - Halted load writes accepted; self-start mode then sets enable.
// - Seconds counter six bits, 0 to 59, steps on each 1 Hz tick.
// - Minutes 0 to 59, hours 0 to 23, each rolling into next field.
// - Weekday counts 1 Sunday to 7 Saturday; 0 invalid.
// - Day of month wraps at 31, 30, 29 or 28 by month and leap year.
// - Month counts 1 to 12; 0 and 13 to 15 invalid.
// - Year counter holds 0 up to 4096.
// - Load registers transfer on the first 1 Hz tick after date load write.
// - After each increment, counters compare to alarms; match raises alarm.
// - Zero month, monthday, weekday or year alarm field is ignored.
// - Alarm interrupt stays until software writes 1 to alarm clear bit.
// - Timer interrupt set by counter borrow, cleared by writing timer clear.
// - Mask bit 0 masks; raw and masked status readable separately.
// - Combined interrupt output is OR of both masked interrupts.
// - 32 kHz clock stops in low-power mode; timer makes no wake-up.
// - Date register packs sec, min, hour, weekday, day, month fields.
`timescale 1ns/1ps
`default_nettype none
module rtcw_top
   import rtcw_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk32k,
   input wire logic i_low_power,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_combined_irq
);
   logic s1, s2, s3, tick32, sec_tick;
   logic [14:0] trim, pre;
   logic [5:0] sec, min;
   logic [4:0] hour, mday;
   logic [2:0] wday;
   logic [3:0] mon;
   logic [15:0] year, yr_load, yr_alm;
   logic [28:0] dt_load, dt_alm;
   logic ld_pend, cmp_pend, match;
   logic [1:0] mask, raw, clr;
   rtcw_tstate_t tstate;
   logic oneshot_select, self_start;
   logic [6:0] plen, pidx;
   logic [31:0] timer_count_value, first_load_value, second_load_value;
   logic [31:0] tin;
   logic [127:0] pattern;
   logic [32:0] tdiff;
   logic borrow, timer_evt, alarm_evt;
   logic wr, rd_acc;
   logic [31:0] rd_mux;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction
   function automatic logic [4:0] mdays(input logic [3:0] m,
      input logic [15:0] y);
      logic [4:0] d;
      d = D_31;
      if (m == M_FEB) begin
         d = (y[1:0] == 2'b00) ? D_29 : D_28;
      end else if (m == M_APR || m == M_JUN || m == M_SEP || m == M_NOV) begin
         d = D_30;
      end
      return d;
   endfunction
   // Bus decode: write takes effect at the edge where ack is sampled
   assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
   assign rd_acc = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire logic [31:0] wd = i_wb_dat;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end else begin
         o_wb_ack <= rd_acc;
         if (rd_acc) begin
            o_wb_dat <= rd_mux;
         end
      end
   end
   always_comb begin
      rd_mux = '0;
      unique case (i_wb_adr)
         A_DT_CNT: rd_mux = {3'h0, mon, mday, wday, hour, min, sec};
         A_DT_ALM: rd_mux = {3'h0, dt_alm};
         A_DT_LD: rd_mux = {3'h0, dt_load};
         A_YR_CNT: rd_mux = {16'h0, year};
         A_YR_ALM: rd_mux = {16'h0, yr_alm};
         A_YR_LD: rd_mux = {16'h0, yr_load};
         A_TRIM: rd_mux = {17'h0, trim};
         A_MASK: rd_mux = {30'h0, mask};
         A_RAW: rd_mux = {30'h0, raw};
         A_MST: rd_mux = {30'h0, raw & mask};
         A_TCNT: rd_mux = timer_count_value;
         A_TCTL: rd_mux = {21'h0, plen, 1'b0, self_start, oneshot_select,
            tstate == T_RUN};
         A_TLD1: rd_mux = first_load_value;
         A_TLD2: rd_mux = second_load_value;
         A_PAT0: rd_mux = pattern[31:0];
         A_PAT0 + 8'h04: rd_mux = pattern[63:32];
         A_PAT0 + 8'h08: rd_mux = pattern[95:64];
         A_PAT0 + 8'h0C: rd_mux = pattern[127:96];
         A_TIN: rd_mux = tin;
         default: rd_mux = '0;
      endcase
   end
   // 32 kHz input synchroniser and edge detect
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= i_clk32k;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign tick32 = s2 & ~s3 & ~i_low_power;
   // Prescaler to 1 Hz
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         trim <= RST_TRIM;
         pre <= '0;
      end else begin
         if (wr && i_wb_adr == A_TRIM) begin
            trim <= 15'(merge({17'h0, trim}, wd, i_wb_sel));
         end
         if (tick32) begin
            pre <= (pre >= trim) ? 15'h0000 : pre + 15'h0001;
         end
      end
   end
   assign sec_tick = tick32 && pre >= trim;
   // Clock watch load, alarm and year registers
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         dt_load <= '0;
         dt_alm <= '0;
         yr_load <= '0;
         yr_alm <= RST_YALM;
         ld_pend <= 1'b0;
      end else begin
         if (wr && i_wb_adr == A_DT_LD) begin
            dt_load <= 29'(merge({3'h0, dt_load}, wd, i_wb_sel));
            ld_pend <= 1'b1;
         end else if (sec_tick) begin
            ld_pend <= 1'b0;
         end
         if (wr && i_wb_adr == A_DT_ALM) begin
            dt_alm <= 29'(merge({3'h0, dt_alm}, wd, i_wb_sel));
         end
         if (wr && i_wb_adr == A_YR_LD) begin
            yr_load <= 16'(merge({16'h0, yr_load}, wd, i_wb_sel));
         end
         if (wr && i_wb_adr == A_YR_ALM) begin
            yr_alm <= 16'(merge({16'h0, yr_alm}, wd, i_wb_sel));
         end
      end
   end
   // Clock watch counters
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sec <= RST_SEC;
         min <= RST_MIN;
         hour <= RST_HOUR;
         wday <= RST_WDAY;
         mday <= RST_MDAY;
         mon <= RST_MON;
         year <= RST_YEAR;
      end else if (sec_tick && ld_pend) begin
         sec <= dt_load[MIN_L-1:SEC_L];
         min <= dt_load[HOUR_L-1:MIN_L];
         hour <= dt_load[WDAY_L-1:HOUR_L];
         wday <= dt_load[MDAY_L-1:WDAY_L];
         mday <= dt_load[MON_L-1:MDAY_L];
         mon <= dt_load[MON_H:MON_L];
         year <= yr_load;
      end else if (sec_tick) begin
         sec <= (sec >= SEC_MAX) ? 6'h00 : sec + 6'h01;
         if (sec >= SEC_MAX) begin
            min <= (min >= MIN_MAX) ? 6'h00 : min + 6'h01;
            if (min >= MIN_MAX) begin
               hour <= (hour >= HOUR_MAX) ? 5'h00 : hour + 5'h01;
               if (hour >= HOUR_MAX) begin
                  wday <= (wday >= WDAY_MAX) ? 3'h1 : wday + 3'h1;
                  if (mday >= mdays(mon, year)) begin
                     mday <= 5'h01;
                     if (mon >= MON_MAX) begin
                        mon <= 4'h1;
                        year <= (year >= YEAR_MAX) ? 16'h0000
                           : year + 16'h0001;
                     end else begin
                        mon <= mon + 4'h1;
                     end
                  end else begin
                     mday <= mday + 5'h01;
                  end
               end
            end
         end
      end
   end
   // Alarm compare one cycle after each increment
   always_comb begin
      match = sec == dt_alm[MIN_L-1:SEC_L]
         && min == dt_alm[HOUR_L-1:MIN_L]
         && hour == dt_alm[WDAY_L-1:HOUR_L]
         && (dt_alm[MDAY_L-1:WDAY_L] == 3'h0
            || wday == dt_alm[MDAY_L-1:WDAY_L])
         && (dt_alm[MON_L-1:MDAY_L] == 5'h00
            || mday == dt_alm[MON_L-1:MDAY_L])
         && (dt_alm[MON_H:MON_L] == 4'h0
            || mon == dt_alm[MON_H:MON_L])
         && (yr_alm == 16'h0000 || year == yr_alm);
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         cmp_pend <= 1'b0;
      end else begin
         cmp_pend <= sec_tick;
      end
   end
   assign alarm_evt = cmp_pend & match;
   // Timer
   assign tdiff = {1'b0, timer_count_value} - 33'h000000001;
   assign borrow = tdiff[32];
   assign timer_evt = tick32 && tstate == T_RUN && borrow;
   generate
      for (genvar g = 0; g < PAT_WORDS; g++) begin : g_pat
         always_ff @(posedge i_clock) begin
            if (!i_rst_n) begin
               pattern[g*32 +: 32] <= '0;
            end else if (wr && i_wb_adr == A_PAT0 + 8'(4*g)) begin
               pattern[g*32 +: 32] <= merge(pattern[g*32 +: 32], wd,
                  i_wb_sel);
            end
         end
      end
   endgenerate
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         first_load_value <= '0;
         second_load_value <= '0;
         oneshot_select <= 1'b0;
         self_start <= 1'b0;
         plen <= '0;
      end else begin
         if (wr && i_wb_adr == A_TLD1 && tstate == T_STOP) begin
            first_load_value <= merge(first_load_value, wd, i_wb_sel);
         end
         if (wr && i_wb_adr == A_TLD2 && tstate == T_STOP) begin
            second_load_value <= merge(second_load_value, wd, i_wb_sel);
         end
         if (wr && i_wb_adr == A_TCTL) begin
            oneshot_select <= wd[TC_OS];
            self_start <= wd[TC_SELF];
            plen <= wd[TC_PL_H:TC_PL_L];
         end
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tstate <= T_STOP;
         timer_count_value <= RST_TCNT;
         pidx <= '0;
         tin <= '0;
      end else begin
         if (timer_evt) begin
            tin <= tin + 32'h00000001;
         end
         if (wr && i_wb_adr == A_TCTL) begin
            if (wd[TC_EN] && tstate == T_STOP) begin
               tstate <= T_RUN;
               timer_count_value <= first_load_value;
               pidx <= '0;
            end else if (!wd[TC_EN]) begin
               tstate <= T_STOP;
            end
         end else if (wr && i_wb_adr == A_TLD1 && tstate == T_STOP) begin
            timer_count_value <= merge(first_load_value, wd, i_wb_sel);
            if (self_start) begin
               tstate <= T_RUN;
            end
         end else if (wr && i_wb_adr == A_TLD2 && tstate == T_STOP) begin
            if (self_start) begin
               tstate <= T_RUN;
               timer_count_value <= first_load_value;
            end
         end else if (timer_evt) begin
            pidx <= (pidx == plen - 7'h01) ? 7'h00 : pidx + 7'h01;
            if (oneshot_select) begin
               tstate <= T_STOP;
            end else begin
               timer_count_value <= pattern[pidx] ? second_load_value
                  : first_load_value;
            end
         end else if (tick32 && tstate == T_RUN) begin
            timer_count_value <= tdiff[31:0];
         end
      end
   end
   // Interrupt status, mask and clear; a new event beats a clear
   assign clr = (wr && i_wb_adr == A_CLR) ? i_wb_dat[1:0] & {2{i_wb_sel[0]}}
      : 2'b00;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         raw <= '0;
         mask <= '0;
         o_combined_irq <= 1'b0;
      end else begin
         raw[IRQ_ALM] <= alarm_evt | (raw[IRQ_ALM] & ~clr[IRQ_ALM]);
         raw[IRQ_TMR] <= timer_evt | (raw[IRQ_TMR] & ~clr[IRQ_TMR]);
         if (wr && i_wb_adr == A_MASK) begin
            mask <= 2'(merge({30'h0, mask}, wd, i_wb_sel));
         end
         o_combined_irq <= |(raw & mask);
      end
   end
   property p_dec;
      tick32 && tstate == T_RUN && !borrow && !wr
      |=> timer_count_value == $past(timer_count_value) - 32'h00000001;
   endproperty
   a_dec: assert property (p_dec) else $error("timer missed a step");
   property p_reload;
      timer_evt && !oneshot_select && !wr
      |=> timer_count_value == ($past(pattern[pidx]) ?
         $past(second_load_value) : $past(first_load_value));
   endproperty
   a_reload: assert property (p_reload) else $error("bad reload");
   property p_halt;
      timer_evt && oneshot_select && !wr |=> tstate == T_STOP
         && timer_count_value == 32'h00000000;
   endproperty
   a_halt: assert property (p_halt) else $error("oneshot did not halt");
   property p_ldlock;
      tstate == T_RUN && wr && (i_wb_adr == A_TLD1 || i_wb_adr == A_TLD2)
      |=> $stable(first_load_value) && $stable(second_load_value);
   endproperty
   a_ldlock: assert property (p_ldlock) else $error("load changed");
   property p_secwrap;
      sec_tick && !ld_pend && sec == SEC_MAX |=> sec == 6'h00;
   endproperty
   a_secwrap: assert property (p_secwrap) else $error("sec wrap");
   property p_xfer;
      sec_tick && ld_pend |=> sec == $past(dt_load[MIN_L-1:SEC_L])
         && year == $past(yr_load)
         && ld_pend == $past(wr && i_wb_adr == A_DT_LD);
   endproperty
   a_xfer: assert property (p_xfer) else $error("load not moved");
   property p_alarm;
      sec_tick ##1 match |=> raw[IRQ_ALM];
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm missed");
   property p_sticky;
      raw[IRQ_ALM] && !clr[IRQ_ALM] |=> raw[IRQ_ALM];
   endproperty
   a_sticky: assert property (p_sticky) else $error("alarm dropped");
   property p_tirq;
      timer_evt |=> raw[IRQ_TMR];
   endproperty
   a_tirq: assert property (p_tirq) else $error("timer irq missed");
   property p_or;
      ##1 o_combined_irq == |($past(raw) & $past(mask));
   endproperty
   a_or: assert property (p_or) else $error("combined irq wrong");
   property p_lp;
      i_low_power && !wr |=> $stable(timer_count_value) && $stable(sec);
   endproperty
   a_lp: assert property (p_lp) else $error("tick in low power");
   c_reload: cover property (@(posedge i_clock) timer_evt && !oneshot_select);
   c_oneshot: cover property (@(posedge i_clock) timer_evt && oneshot_select);
   c_alarm: cover property (@(posedge i_clock) alarm_evt);
   c_xfer: cover property (@(posedge i_clock) sec_tick && ld_pend);
endmodule
`default_nettype wire

// file: dv/rtc_timer_and_clock_watch_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_and_clock_watch_bench
   import rtcw_pkg::*;
;
   localparam logic [31:0] F = 32'hFFFFFFFF;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic clk32 = 1'b0;
   logic lp = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   wire logic [31:0] rdat;
   wire logic ack;
   wire logic irq;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int i;
   int j;
   logic [31:0] eq[$];
   logic [31:0] mq[$];
   logic [31:0] rd;
   logic [31:0] ev;
   logic [31:0] mv;
   logic [31:0] ld;
   logic [31:0] rs = 32'h0000E487;
   logic [15:0] y0[6] = '{16'h07E5, 16'h07E8, 16'h07E8, 16'h07E8,
      16'h07E9, 16'h1000};
   logic [15:0] y1[6] = '{16'h07E5, 16'h07E8, 16'h07E8, 16'h07E9,
      16'h07E9, 16'h0000};
   logic [3:0] m0[6] = '{4'h2, 4'h2, 4'h4, 4'hC, 4'h1, 4'hC};
   logic [4:0] d0[6] = '{5'h1C, 5'h1C, 5'h1E, 5'h1F, 5'h1F, 5'h1F};
   logic [3:0] m1[6] = '{4'h3, 4'h2, 4'h5, 4'h1, 4'h2, 4'h1};
   logic [4:0] d1[6] = '{5'h01, 5'h1D, 5'h01, 5'h01, 5'h01, 5'h01};

   always #20 i_clock = ~i_clock;

   rtcw_top u_rtcw_top (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clk32k(clk32),
      .i_low_power(lp),
      .i_wb_cyc(cyc),
      .i_wb_stb(stb),
      .i_wb_we(we),
      .i_wb_adr(adr),
      .i_wb_sel(sel),
      .i_wb_dat(wdat),
      .o_wb_dat(rdat),
      .o_wb_ack(ack),
      .o_combined_irq(irq)
   );

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   function automatic logic [31:0] dt(input logic [4:0] h,
      input logic [5:0] mi, input logic [5:0] s, input logic [2:0] w,
      input logic [4:0] md, input logic [3:0] mo);
      return {3'h0, mo, md, w, h, mi, s};
   endfunction

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      @(posedge i_clock);
      while (ack !== 1'b1) @(posedge i_clock);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   // Read with an expected value noted for the monitor
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      eq.push_back(e);
      mq.push_back(m);
      bus(1'b0, a, 32'h00000000);
   endtask

   task automatic ck(input logic e);
      @(negedge i_clock);
      check_count++;
      if (irq !== e) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, irq, e);
      end
      @(posedge i_clock);
   endtask

   // n slow-clock periods, accelerated
   task automatic tk(input int n);
      repeat (n) begin
         clk32 <= 1'b1;
         repeat (4) @(posedge i_clock);
         clk32 <= 1'b0;
         repeat (4) @(posedge i_clock);
      end
   endtask

   task automatic cw(input int k);
      wr(A_YR_LD, {16'h0000, y0[k]});
      wr(A_DT_LD, dt(5'h17, 6'h3B, 6'h3B, 3'h7, d0[k], m0[k]));
      rd = 32'h00000000;
      j = 0;
      while (rd !== dt(5'h17, 6'h3B, 6'h3B, 3'h7, d0[k], m0[k]) && j < 8) begin
         tk(1);
         rc(A_DT_CNT, 32'h00000000, 32'h00000000);
         j++;
      end
      rc(A_YR_CNT, {16'h0000, y0[k]}, F);
      tk(2);
      rc(A_DT_CNT, dt(5'h00, 6'h00, 6'h00, 3'h1, d1[k], m1[k]), F);
      rc(A_YR_CNT, {16'h0000, y1[k]}, F);
   endtask

   always @(posedge i_clock) begin
      if (ack === 1'b1 && we === 1'b0 && eq.size() > 0) begin
         ev = eq.pop_front();
         mv = mq.pop_front();
         if (mv != 32'h00000000) begin
            check_count++;
            if ((rdat & mv) !== (ev & mv)) begin
               num_errors++;
               $display("[ERR] t=%0t got %h exp %h", $time, rdat, ev);
            end
         end
      end
   end

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, cycles, 0);
         final_report();
      end
   end

   initial begin
      repeat (6) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      rc(A_DT_CNT, 32'h02120000, F);
      rc(A_YR_CNT, 32'h00002000, F);
      rc(A_YR_ALM, 32'h00002000, F);
      rc(A_TRIM, 32'h00007FFF, F);
      rc(A_TCNT, 32'h0FFFFFFF, F);
      rc(A_RAW, 32'h00000000, F);
      wr(8'h80, xs());
      rc(8'h80, 32'h00000000, F);
      rc(A_CLR, 32'h00000000, F);
      $display("test reset done");
      wr(A_TRIM, 32'h00000001);
      wr(A_MASK, 32'h00000003);
      ld = 32'h00000002 + (xs() & 32'h00000003);
      wr(A_TLD1, ld);
      wr(A_TCTL, 32'h00000003);
      tk(int'(ld));
      rc(A_RAW, 32'h00000000, 32'h00000002);
      rc(A_TCNT, 32'h00000000, F);
      tk(1);
      rc(A_RAW, 32'h00000002, 32'h00000002);
      ck(1'b1);
      rc(A_TCTL, 32'h00000002, 32'h00000007);
      rc(A_TIN, 32'h00000001, F);
      wr(A_CLR, 32'h00000002);
      rc(A_RAW, 32'h00000000, 32'h00000002);
      wr(A_TCTL, 32'h00000006);
      wr(A_TLD1, ld + 32'h00000001);
      rc(A_TLD1, ld + 32'h00000001, F);
      rc(A_TCTL, 32'h00000007, 32'h00000007);
      tk(int'(ld) + 2);
      rc(A_TIN, 32'h00000002, F);
      wr(A_TLD2, 32'h00000004);
      rc(A_TLD2, 32'h00000004, F);
      rc(A_TCTL, 32'h00000007, 32'h00000007);
      tk(int'(ld) + 2);
      rc(A_TIN, 32'h00000003, F);
      $display("test oneshot done");
      wr(A_TCTL, 32'h00000000);
      wr(A_CLR, 32'h00000002);
      wr(A_TLD1, 32'h00000001);
      wr(A_TLD2, 32'h00000003);
      wr(A_PAT0, (xs() & 32'hFFFFFFFC) | 32'h00000002);
      for (i = 1; i < PAT_WORDS; i++) wr(A_PAT0 + 8'(4 * i), xs());
      wr(A_TCTL, 32'h00000021);
      wr(A_TLD1, 32'h00000007);
      wr(A_TLD2, 32'h00000009);
      rc(A_TLD1, 32'h00000001, F);
      rc(A_TLD2, 32'h00000003, F);
      tk(8);
      rc(A_TIN, 32'h00000006, F);
      tk(6);
      rc(A_TIN, 32'h00000008, F);
      wr(A_MASK, 32'h00000001);
      rc(A_MST, 32'h00000000, 32'h00000002);
      rc(A_RAW, 32'h00000002, 32'h00000002);
      ck(1'b0);
      wr(A_MASK, 32'h00000003);
      rc(A_MST, 32'h00000002, 32'h00000002);
      ck(1'b1);
      wr(A_TCTL, 32'h00000000);
      wr(A_CLR, 32'h00000002);
      rc(A_RAW, 32'h00000000, 32'h00000002);
      $display("test periodic done");
      wr(A_DT_ALM, dt(5'h00, 6'h00, 6'h00, 3'h1, 5'h00, 4'h0));
      for (i = 0; i < 6; i++) cw(i);
      rc(A_RAW, 32'h00000000, 32'h00000001);
      $display("test calendar done");
      wr(A_YR_ALM, 32'h00000000);
      cw(0);
      rc(A_RAW, 32'h00000001, 32'h00000001);
      tk(2);
      rc(A_RAW, 32'h00000001, 32'h00000001);
      wr(A_MASK, 32'h00000001);
      ck(1'b1);
      wr(A_CLR, 32'h00000001);
      rc(A_RAW, 32'h00000000, 32'h00000001);
      ck(1'b0);
      $display("test alarm done");
      lp <= 1'b1;
      tk(4);
      rc(A_DT_CNT, dt(5'h00, 6'h00, 6'h01, 3'h1, 5'h01, 4'h3), F);
      lp <= 1'b0;
      $display("test lowpower done");
      final_report();
   end
endmodule
`default_nettype wire
